// >>> nax_pkg.sv
// nax_pkg: opcodes, widths, cycle counts and reset values of the nibble execution core
package nax_pkg;
  typedef enum logic [5:0] {
    OP_NOP, OP_MEM_INC, OP_MEM_DEC, OP_ADD_MEM, OP_XOR_MEM, OP_AND_MEM, OP_OR_MEM,
    OP_SUB_MEM, OP_STORE_ACC, OP_LOAD_ACC_MEM, OP_MEM_RR_C, OP_MEM_RL_C,
    OP_SUB_LIT, OP_ADD_LIT, OP_XOR_LIT, OP_AND_LIT, OP_OR_LIT, OP_LOAD_LIT,
    OP_ACC_RR, OP_ACC_RL, OP_ACC_RR_C, OP_ACC_RL_C, OP_CARRY_CLR, OP_CARRY_SET,
    OP_ACC_INC, OP_ACC_DEC, OP_SKIP_GT, OP_SKIP_LT, OP_SKIP_NE, OP_SKIP_C0,
    OP_SKIP_C1, OP_SKIP_Z0, OP_SKIP_Z1, OP_SKIP_BIT0, OP_TABLE_FETCH,
    OP_TABLE_FETCH_ADV, OP_JUMP, OP_CALL, OP_TIMER_RELOAD
  } nax_op_t;
  localparam int          NAX_ADDR_W      = 9;
  localparam int          NAX_PC_W        = 13;
  localparam int          NAX_ROM_W       = 10;
  localparam int          NAX_TMR_W       = 12;
  localparam logic [8:0]  NAX_SHORT_LIMIT = 9'h03F;  // last one-word operand address
  localparam logic [1:0]  NAX_CYC_ONE     = 2'h1;
  localparam logic [1:0]  NAX_CYC_TWO     = 2'h2;
  localparam logic [1:0]  NAX_CYC_THREE   = 2'h3;
  localparam logic [12:0] NAX_CALL_STEP   = 13'h0002;
  localparam logic [3:0]  NAX_ACC_RESET   = 4'h0;
  localparam logic        NAX_FLAG_RESET  = 1'b0;
endpackage

// >>> nax_rot.sv
// nax_rot: one-position rotate of a nibble, optionally through the carry bit
`timescale 1ns/10ps
module nax_rot (
  input  wire logic       left,
  input  wire logic       thruCarry,
  input  wire logic [3:0] dIn,
  input  wire logic       cIn,
  output logic      [3:0] dOut,
  output logic            cOut
);
  wire [3:0] rrPlain = {dIn[0], dIn[3:1]};
  wire [3:0] rlPlain = {dIn[2:0], dIn[3]};
  wire [3:0] rrCarry = {cIn, dIn[3:1]};
  wire [3:0] rlCarry = {dIn[2:0], cIn};
  // plain rotate keeps carry, through-carry rotate moves the end bit into it
  assign dOut = thruCarry ? (left ? rlCarry : rrCarry) : (left ? rlPlain : rrPlain);
  assign cOut = thruCarry ? (left ? dIn[3] : dIn[0]) : cIn;
endmodule

// >>> nax_exec.sv
// nax_exec: execution datapath of the nibble core (alu, flags, skips, table read)
// Operation
// - memory operands below 0x40 take one word and cycle, from 0x40 up take two
// - add-memory adds acc, memory and carry; carry-out to carry, zero updated
// - borrow is inverse carry; sub-memory sets carry when no borrow
// - sub-literal subtracts literal and borrow, one cycle, same convention
// - add-literal adds literal and carry, one cycle, carry and zero updated
// - memory xor/and/or into acc affect only zero
// - literal xor/and/or into acc in one cycle affect only zero
// - store acc copies acc to memory, flags unchanged
// - load acc from memory updates zero, carry unchanged
// - load literal into acc in one cycle, no flag change
// - memory rotates move carry and nibble chain, write back, update zero
// - plain acc rotates wrap end bits, no flags touched
// - acc rotates through carry move five-bit chain, update carry and zero
// - carry clear and carry set instructions touch only carry
// - acc increment/decrement modulo 16 update carry and zero
// - memory increment/decrement modulo 16; decrement of zero clears carry
// - one-word skips on compare, carry, zero or acc bit; one cycle
// - jump and call two words two cycles; call saves pc plus two
// - table read takes three cycles into top, mid and acc; advance bumps pointer
// - timer reload copies initial latch into counter in one cycle
`timescale 1ns/10ps
module nax_exec
  import nax_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  issue,          // one-cycle start of an instruction
  input  wire nax_pkg::nax_op_t      opcode,
  input  wire logic [3:0]            literal,        // literal or bit index in [1:0]
  input  wire logic [8:0]            memAddr,
  input  wire logic [3:0]            memRdData,      // addressed nibble, valid with issue
  input  wire logic [12:0]           target,         // jump or call address
  input  wire logic [12:0]           pcNow,          // address of the issued instruction
  input  wire logic [9:0]            romData,        // table word, valid during table read
  input  wire logic [11:0]           timerLatch,
  output logic                       busy,           // instruction still in progress
  output logic                       done,           // pulses the cycle after the instruction's last cycle
  output logic [1:0]                 wordCount,      // words used by the instruction
  output logic                       skipNext,       // discard the next instruction
  output logic                       pcLoad,
  output logic [12:0]                pcNew,
  output logic                       memWr,
  output logic [8:0]                 memWrAddr,
  output logic [3:0]                 memWrData,
  output logic [3:0]                 acc,
  output logic                       carry,
  output logic                       zero,
  output logic [12:0]                multiPointer,
  output logic [12:0]                tablePointer,
  output logic [12:0]                romAddr,
  output logic [3:0]                 tableMidNibble,
  output logic [1:0]                 tableTopBits,
  output logic                       timerLoad,
  output logic [11:0]                timerValue
);
  import nax_pkg::*;

  // ------------------------------------------------------------------
  // operand decode
  // ------------------------------------------------------------------
  wire        isMemOp   = (opcode inside {OP_MEM_INC, OP_MEM_DEC, OP_ADD_MEM, OP_XOR_MEM,
                          OP_AND_MEM, OP_OR_MEM, OP_SUB_MEM, OP_STORE_ACC,
                          OP_LOAD_ACC_MEM, OP_MEM_RR_C, OP_MEM_RL_C});
  wire        longAddr  = (memAddr > NAX_SHORT_LIMIT);
  wire        isTable   = (opcode == OP_TABLE_FETCH) || (opcode == OP_TABLE_FETCH_ADV);
  wire        isFar     = (opcode == OP_JUMP) || (opcode == OP_CALL);
  wire        isSkip    = (opcode inside {OP_SKIP_GT, OP_SKIP_LT, OP_SKIP_NE, OP_SKIP_C0,
                          OP_SKIP_C1, OP_SKIP_Z0, OP_SKIP_Z1, OP_SKIP_BIT0});
  // high addresses need an extra operand word, hence the extra cycle
  wire [1:0]  opCycles  = isTable ? NAX_CYC_THREE :
                          (isFar || (isMemOp && longAddr)) ? NAX_CYC_TWO :
                          NAX_CYC_ONE;
  wire [1:0]  opWords   = ((isMemOp && longAddr) || isFar) ? NAX_CYC_TWO : NAX_CYC_ONE;

  // ------------------------------------------------------------------
  // arithmetic: 5-bit sums carry the carry-out in bit 4
  // ------------------------------------------------------------------
  wire        borrowIn  = ~carry;
  wire [4:0]  sumMem    = {1'b0, acc} + {1'b0, memRdData} + {4'h0, carry};
  wire [4:0]  sumLit    = {1'b0, acc} + {1'b0, literal} + {4'h0, carry};
  wire [4:0]  difMem    = {1'b0, acc} - {1'b0, memRdData} - {4'h0, borrowIn};
  wire [4:0]  difLit    = {1'b0, acc} - {1'b0, literal} - {4'h0, borrowIn};
  wire [4:0]  accInc    = {1'b0, acc} + 5'h01;
  wire [4:0]  accDec    = {1'b0, acc} - 5'h01;
  wire [4:0]  memInc    = {1'b0, memRdData} + 5'h01;
  wire [4:0]  memDec    = {1'b0, memRdData} - 5'h01;

  // ------------------------------------------------------------------
  // rotates: one shared rotator, fed by acc or by memory
  // ------------------------------------------------------------------
  wire        rotMem    = (opcode == OP_MEM_RR_C) || (opcode == OP_MEM_RL_C);
  wire        rotLeft   = (opcode inside {OP_MEM_RL_C, OP_ACC_RL, OP_ACC_RL_C});
  wire        rotThru   = (opcode inside {OP_MEM_RR_C, OP_MEM_RL_C, OP_ACC_RR_C,
                          OP_ACC_RL_C});
  wire [3:0]  rotOut;
  wire        rotCarry;

  nax_rot u_rot (
    .left      (rotLeft),
    .thruCarry (rotThru),
    .dIn       (rotMem ? memRdData : acc),
    .cIn       (carry),
    .dOut      (rotOut),
    .cOut      (rotCarry)
  );

  // ------------------------------------------------------------------
  // result select: next acc, carry, memory and zero-update enable
  // ------------------------------------------------------------------
  logic [3:0] next_acc;
  logic       next_carry;
  logic       zUpd;
  logic       mWr;
  logic [3:0] mData;

  always_comb begin
    next_acc   = acc;
    next_carry = carry;
    zUpd       = 1'b0;
    mWr        = 1'b0;
    mData      = acc;
    unique case (opcode)
      OP_MEM_INC: begin
        mWr        = 1'b1;
        mData      = memInc[3:0];
        next_carry = memInc[4];
        zUpd       = 1'b1;
      end
      OP_MEM_DEC: begin
        mWr        = 1'b1;
        mData      = memDec[3:0];
        next_carry = ~memDec[4];                         // wrap below zero is a borrow
        zUpd       = 1'b1;
      end
      OP_ADD_MEM: begin
        next_acc   = sumMem[3:0];
        next_carry = sumMem[4];
        zUpd       = 1'b1;
      end
      OP_SUB_MEM: begin
        next_acc   = difMem[3:0];
        next_carry = ~difMem[4];
        zUpd       = 1'b1;
      end
      OP_XOR_MEM: begin
        next_acc   = acc ^ memRdData;
        zUpd       = 1'b1;
      end
      OP_AND_MEM: begin
        next_acc   = acc & memRdData;
        zUpd       = 1'b1;
      end
      OP_OR_MEM: begin
        next_acc   = acc | memRdData;
        zUpd       = 1'b1;
      end
      OP_STORE_ACC: begin
        mWr        = 1'b1;
        mData      = acc;
      end
      OP_LOAD_ACC_MEM: begin
        next_acc   = memRdData;
        zUpd       = 1'b1;
      end
      OP_MEM_RR_C,
      OP_MEM_RL_C: begin
        mWr        = 1'b1;
        mData      = rotOut;
        next_carry = rotCarry;
        zUpd       = 1'b1;
      end
      OP_SUB_LIT: begin
        next_acc   = difLit[3:0];
        next_carry = ~difLit[4];
        zUpd       = 1'b1;
      end
      OP_ADD_LIT: begin
        next_acc   = sumLit[3:0];
        next_carry = sumLit[4];
        zUpd       = 1'b1;
      end
      OP_XOR_LIT: begin
        next_acc   = acc ^ literal;
        zUpd       = 1'b1;
      end
      OP_AND_LIT: begin
        next_acc   = acc & literal;
        zUpd       = 1'b1;
      end
      OP_OR_LIT: begin
        next_acc   = acc | literal;
        zUpd       = 1'b1;
      end
      OP_LOAD_LIT:     next_acc = literal;
      OP_ACC_RR,
      OP_ACC_RL:       next_acc = rotOut;
      OP_ACC_RR_C,
      OP_ACC_RL_C: begin
        next_acc   = rotOut;
        next_carry = rotCarry;
        zUpd       = 1'b1;
      end
      OP_CARRY_CLR:    next_carry = 1'b0;
      OP_CARRY_SET:    next_carry = 1'b1;
      OP_ACC_INC: begin
        next_acc   = accInc[3:0];
        next_carry = accInc[4];
        zUpd       = 1'b1;
      end
      OP_ACC_DEC: begin
        next_acc   = accDec[3:0];
        next_carry = ~accDec[4];
        zUpd       = 1'b1;
      end
      default:         next_acc = acc;
    endcase
  end

  // zero follows whichever nibble the instruction produced
  wire [3:0]  zSrc      = mWr ? mData : next_acc;
  wire        next_zero = zUpd ? (zSrc == 4'h0) : zero;

  // ------------------------------------------------------------------
  // skip condition
  // ------------------------------------------------------------------
  logic skipCond;
  always_comb begin
    skipCond = 1'b0;
    unique case (opcode)
      OP_SKIP_GT:   skipCond = (acc > literal);
      OP_SKIP_LT:   skipCond = (acc < literal);
      OP_SKIP_NE:   skipCond = (acc != literal);
      OP_SKIP_C0:   skipCond = ~carry;
      OP_SKIP_C1:   skipCond = carry;
      OP_SKIP_Z0:   skipCond = ~zero;
      OP_SKIP_Z1:   skipCond = zero;
      OP_SKIP_BIT0: skipCond = ~acc[literal[1:0]];
      default:      skipCond = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // sequencing: cycles left of the current multi-cycle instruction
  // ------------------------------------------------------------------
  logic [1:0] cycLeft;
  nax_op_t    heldOp;
  wire        start     = issue && !busy;
  wire        lastCyc   = busy && (cycLeft == NAX_CYC_ONE);
  wire        finish    = start ? (opCycles == NAX_CYC_ONE) : lastCyc;
  // alu results commit on the issue cycle, the same cycle the operands are sampled
  wire        commitAlu = start && !isTable && !isFar && !isSkip;
  wire        tblDone   = lastCyc && (heldOp inside {OP_TABLE_FETCH, OP_TABLE_FETCH_ADV});

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cycLeft <= 2'h0;
      heldOp  <= OP_NOP;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= finish;
      if (start && opCycles != NAX_CYC_ONE) begin
        cycLeft <= opCycles - NAX_CYC_ONE;
        heldOp  <= opcode;
        busy    <= 1'b1;
      end else if (busy) begin
        cycLeft <= cycLeft - NAX_CYC_ONE;
        busy    <= !lastCyc;
      end
    end
  end

  // ------------------------------------------------------------------
  // acc and flags; acc also loaded by the table read
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc   <= NAX_ACC_RESET;
      carry <= NAX_FLAG_RESET;
      zero  <= NAX_FLAG_RESET;
    end else if (tblDone) begin
      acc <= romData[3:0];
    end else if (commitAlu) begin
      acc   <= next_acc;
      carry <= next_carry;
      zero  <= next_zero;
    end
  end

  // memory write port, one-cycle pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memWr     <= 1'b0;
      memWrAddr <= 9'h000;
      memWrData <= 4'h0;
    end else begin
      memWr <= commitAlu && mWr;
      if (commitAlu && mWr) begin
        memWrAddr <= memAddr;
        memWrData <= mData;
      end
    end
  end

  // ------------------------------------------------------------------
  // control flow: skip, jump, call
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      skipNext     <= 1'b0;
      pcLoad       <= 1'b0;
      pcNew        <= 13'h0000;
      multiPointer <= 13'h0000;
      wordCount    <= 2'h0;
    end else begin
      skipNext <= start && isSkip && skipCond;
      pcLoad   <= start && isFar;
      if (start) begin
        wordCount <= opWords;
      end
      if (start && isFar) begin
        pcNew <= target;
      end
      if (start && opcode == OP_CALL) begin
        multiPointer <= pcNow + NAX_CALL_STEP;
      end
    end
  end

  // ------------------------------------------------------------------
  // table read and timer reload
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tablePointer   <= 13'h0000;
      romAddr        <= 13'h0000;
      tableMidNibble <= 4'h0;
      tableTopBits   <= 2'h0;
    end else begin
      romAddr <= tablePointer;
      if (tblDone) begin
        tableMidNibble <= romData[7:4];
        tableTopBits   <= romData[9:8];
        if (heldOp == OP_TABLE_FETCH_ADV) begin
          tablePointer <= tablePointer + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timerLoad  <= 1'b0;
      timerValue <= 12'h000;
    end else begin
      timerLoad <= start && (opcode == OP_TIMER_RELOAD);
      if (start && opcode == OP_TIMER_RELOAD) begin
        timerValue <= timerLatch;
      end
    end
  end
endmodule

// >>> nax_exec_properties.sv
// nax_exec_properties: concurrent checks on the ports of the execution core
`timescale 1ns/10ps
module nax_exec_properties
  import nax_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rst_b,
  input wire logic             issue,
  input wire nax_pkg::nax_op_t opcode,
  input wire logic [3:0]       literal,
  input wire logic [8:0]       memAddr,
  input wire logic [12:0]      target,
  input wire logic [12:0]      pcNow,
  input wire logic [11:0]      timerLatch,
  input wire logic             busy,
  input wire logic [1:0]       wordCount,
  input wire logic             skipNext,
  input wire logic             pcLoad,
  input wire logic [12:0]      pcNew,
  input wire logic             memWr,
  input wire logic [3:0]       memWrData,
  input wire logic [3:0]       acc,
  input wire logic             carry,
  input wire logic             zero,
  input wire logic [12:0]      multiPointer,
  input wire logic             timerLoad,
  input wire logic [11:0]      timerValue
);
  logic taken;
  logic memOp;
  // -----------------------------------------------------------------
  // request decode
  // -----------------------------------------------------------------
  // an issue while busy is refused, so only this qualifies an antecedent
  assign taken = issue && !busy;
  assign memOp = opcode inside {[OP_MEM_INC:OP_MEM_RL_C]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  a_short_mem: assert property (
    taken && memOp && memAddr <= NAX_SHORT_LIMIT |=> !busy && wordCount == 2'h1)
    else $error("short memory op not single word and cycle");
  a_long_mem: assert property (
    taken && memOp && memAddr > NAX_SHORT_LIMIT |=> busy && wordCount == 2'h2 ##1 !busy)
    else $error("long memory op not two words and cycles");
  a_table_three: assert property (
    taken && opcode inside {OP_TABLE_FETCH, OP_TABLE_FETCH_ADV} |=> busy[*2] ##1 !busy)
    else $error("table read not three cycles");
  a_store_flags: assert property (
    taken && opcode == OP_STORE_ACC
    |=> memWr && memWrData == $past(acc) && $stable(carry) && $stable(zero))
    else $error("store wrong data or flags moved");
  a_load_literal: assert property (
    taken && opcode == OP_LOAD_LIT |=> acc == $past(literal) && $stable({carry, zero}))
    else $error("literal load wrong");
  a_logic_zero: assert property (
    taken && opcode inside {OP_XOR_LIT, OP_AND_LIT, OP_OR_LIT}
    |=> zero == (acc == 4'h0) && $stable(carry))
    else $error("literal logic op flags wrong");
  a_acc_rotate: assert property (
    taken && opcode == OP_ACC_RR |=> acc == {$past(acc[0]), $past(acc[3:1])} && $stable(carry))
    else $error("plain right rotate wrong");
  a_call_save: assert property (
    taken && opcode == OP_CALL
    |=> pcLoad && pcNew == $past(target) && multiPointer == $past(pcNow) + NAX_CALL_STEP)
    else $error("call target or return address wrong");
  a_timer_copy: assert property (
    taken && opcode == OP_TIMER_RELOAD |=> timerLoad && timerValue == $past(timerLatch))
    else $error("timer reload wrong");
  a_skip_unequal: assert property (
    taken && opcode == OP_SKIP_NE |=> skipNext == ($past(acc) != $past(literal)))
    else $error("unequal skip wrong");
  c_long_mem: cover property (taken && memOp && memAddr > NAX_SHORT_LIMIT);
  c_call: cover property (taken && opcode == OP_CALL);
  c_table: cover property (taken && opcode == OP_TABLE_FETCH_ADV);
endmodule

// >>> tb.sv
// tb: self-checking bench for the nibble execution core against a reference model
`timescale 1ns/10ps
module tb;
  import nax_pkg::*;
  logic sys_clk, rst_b, issue, busy, done, skipNext, pcLoad, memWr, carry, zero, timerLoad;
  nax_op_t     opcode;
  logic [3:0]  literal, memRdData, memWrData, acc, tableMidNibble;
  logic [8:0]  memAddr, memWrAddr;
  logic [12:0] target, pcNow, pcNew, multiPointer, tablePointer, romAddr;
  logic [9:0]  romData;
  logic [11:0] timerLatch, timerValue;
  logic [1:0]  wordCount, tableTopBits;
  int          error_cnt, checks_done, mA, mC, mZ, mTp;
  nax_exec u_nax_exec (.sys_clk(sys_clk), .rst_b(rst_b), .issue(issue), .opcode(opcode),
    .literal(literal), .memAddr(memAddr), .memRdData(memRdData), .target(target),
    .pcNow(pcNow), .romData(romData), .timerLatch(timerLatch), .busy(busy), .done(done),
    .wordCount(wordCount), .skipNext(skipNext), .pcLoad(pcLoad), .pcNew(pcNew),
    .memWr(memWr), .memWrAddr(memWrAddr), .memWrData(memWrData), .acc(acc), .carry(carry),
    .zero(zero), .multiPointer(multiPointer), .tablePointer(tablePointer), .romAddr(romAddr),
    .tableMidNibble(tableMidNibble), .tableTopBits(tableTopBits), .timerLoad(timerLoad),
    .timerValue(timerValue));
  // -----------------------------------------------------------------
  // comparison, verdict, clock
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // -----------------------------------------------------------------
  // one instruction: model it, issue it, compare every result
  // -----------------------------------------------------------------
  task automatic run(input nax_op_t op, input int l, input int ad, input int m);
    int r, n, ea, ec, ez, wr, wd, sk, cyc;
    logic [9:0] rd;
    logic [12:0] tg, pc;
    logic [11:0] tl;
    rd = 10'($urandom);
    tg = 13'($urandom);
    pc = 13'($urandom);
    tl = 12'($urandom);
    cyc = (op inside {[OP_MEM_INC:OP_MEM_RL_C]} && ad > NAX_SHORT_LIMIT) ? 2 : 1;
    ea = mA;
    ec = mC;
    ez = mZ;
    wr = 0;
    wd = 0;
    sk = 0;
    case (op)
      OP_MEM_INC: begin
        r  = m + 1;
        ec = r >> 4;
        wd = r & 15;
        wr = 1;
      end
      OP_MEM_DEC: begin // borrow clears carry
        ec = (m != 0);
        wd = (m - 1) & 15;
        wr = 1;
      end
      OP_MEM_RR_C: begin
        ec = m & 1;
        wd = (mC << 3) | (m >> 1);
        wr = 1;
      end
      OP_MEM_RL_C: begin
        ec = m >> 3;
        wd = ((m << 1) | mC) & 15;
        wr = 1;
      end
      OP_STORE_ACC: begin
        wd = mA;
        wr = 1;
      end
      OP_ADD_MEM, OP_ADD_LIT: begin
        r  = mA + ((op == OP_ADD_MEM) ? m : l) + mC;
        ec = r >> 4;
      end
      OP_SUB_MEM, OP_SUB_LIT: begin
        r  = mA - ((op == OP_SUB_MEM) ? m : l) - (1 - mC);
        ec = r >= 0;
      end
      OP_XOR_MEM, OP_XOR_LIT: r = mA ^ ((op == OP_XOR_MEM) ? m : l);
      OP_AND_MEM, OP_AND_LIT: r = mA & ((op == OP_AND_MEM) ? m : l);
      OP_OR_MEM, OP_OR_LIT: r = mA | ((op == OP_OR_MEM) ? m : l);
      OP_LOAD_ACC_MEM: r = m;
      OP_ACC_RR: ea = ((mA & 1) << 3) | (mA >> 1);
      OP_ACC_RL: ea = ((mA << 1) | (mA >> 3)) & 15;
      OP_ACC_RR_C: begin
        ec = mA & 1;
        r  = (mC << 3) | (mA >> 1);
      end
      OP_ACC_RL_C: begin
        ec = mA >> 3;
        r  = (mA << 1) | mC;
      end
      OP_ACC_INC: begin
        r  = mA + 1;
        ec = r >> 4;
      end
      OP_ACC_DEC: begin
        r  = mA - 1;
        ec = (mA != 0);
      end
      OP_LOAD_LIT: ea = l;
      OP_CARRY_CLR, OP_CARRY_SET: ec = (op == OP_CARRY_SET);
      OP_SKIP_GT: sk = mA > l;
      OP_SKIP_LT: sk = mA < l;
      OP_SKIP_NE: sk = mA != l;
      OP_SKIP_C0, OP_SKIP_C1: sk = mC == (op == OP_SKIP_C1);
      OP_SKIP_Z0, OP_SKIP_Z1: sk = mZ == (op == OP_SKIP_Z1);
      OP_SKIP_BIT0: sk = ((mA >> (l & 3)) & 1) == 0;
      OP_TABLE_FETCH, OP_TABLE_FETCH_ADV: begin
        ea  = rd[3:0];
        cyc = 3;
      end
      OP_JUMP, OP_CALL: cyc = 2;
      default: ;
    endcase
    if (op inside {[OP_ADD_MEM:OP_SUB_MEM], OP_LOAD_ACC_MEM, [OP_SUB_LIT:OP_OR_LIT],
                   OP_ACC_RR_C, OP_ACC_RL_C, OP_ACC_INC, OP_ACC_DEC}) begin
      ea = r & 15;
      ez = (ea == 0);
    end
    if (wr == 1 && op != OP_STORE_ACC) ez = (wd == 0);
    @(posedge sys_clk);
    issue      <= 1'b1;
    opcode     <= op;
    literal    <= 4'(l);
    memAddr    <= 9'(ad);
    memRdData  <= 4'(m);
    romData    <= rd;
    target     <= tg;
    pcNow      <= pc;
    timerLatch <= tl;
    @(posedge sys_clk);
    issue <= 1'b0;
    #1;
    chk(memWr, wr);
    if (wr == 1) chk(memWrData, wd);
    if (wr == 1) chk(memWrAddr, ad);
    chk(skipNext, sk);
    chk(wordCount, (cyc == 2) ? 2 : 1);
    chk(pcLoad, op inside {OP_JUMP, OP_CALL});
    if (op inside {OP_JUMP, OP_CALL}) chk(pcNew, tg);
    if (op == OP_CALL) chk(multiPointer, 13'(pc + 13'h0002));
    chk(timerLoad, op == OP_TIMER_RELOAD);
    if (op == OP_TIMER_RELOAD) chk(timerValue, tl);
    n = 1;
    // bounded wait for the instruction to retire
    while (busy === 1'b1 && n < 6) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n, cyc);
    chk(done, 1);
    // the table address trails the pointer by one edge, so it still shows the old one
    chk(romAddr, mTp);
    if (op == OP_TABLE_FETCH_ADV) mTp = (mTp + 1) & 16'h1FFF;
    if (cyc == 3) chk({tableTopBits, tableMidNibble}, rd[9:4]);
    chk(tablePointer, mTp);
    chk(acc, ea);
    chk(carry, ec);
    chk(zero, ez);
    mA = ea;
    mC = ec;
    mZ = ez;
  endtask
  // -----------------------------------------------------------------
  // main sequence: reset, boundary cases, then a random stream
  // -----------------------------------------------------------------
  initial begin
    rst_b       = 1'b0;
    issue       = 1'b0;
    opcode      = OP_NOP;
    literal     = 4'h0;
    memAddr     = 9'h000;
    memRdData   = 4'h0;
    target      = 13'h0000;
    pcNow       = 13'h0000;
    romData     = 10'h000;
    timerLatch  = 12'h000;
    error_cnt   = 0;
    checks_done = 0;
    mA          = 0;
    mC          = 0;
    mZ          = 0;
    mTp         = 0;
    void'($urandom(32'h982d));
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    chk({acc, carry, zero}, 6'h00);
    run(OP_LOAD_LIT, 15, 0, 0); // wrap of acc increment
    run(OP_ACC_INC, 0, 0, 0);
    run(OP_ACC_DEC, 0, 0, 0);
    run(OP_MEM_DEC, 0, 9'h03F, 0);
    run(OP_ADD_MEM, 0, 9'h040, 10);
    run(OP_SUB_MEM, 0, 9'h1FF, 2);
    for (int i = 0; i < 500; i++)
      run(nax_op_t'($urandom_range(38, 1)), $urandom_range(15, 0),
          ($urandom_range(2, 0) == 0) ? $urandom_range(9'h040, 9'h03F) : $urandom_range(511, 0),
          $urandom_range(15, 0));
    summarize();
  end
  // watchdog well beyond 506 instructions of at most four cycles each
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
endmodule
bind nax_exec nax_exec_properties u_nax_exec_properties (.sys_clk(sys_clk), .rst_b(rst_b),
  .issue(issue), .opcode(opcode), .literal(literal), .memAddr(memAddr), .target(target),
  .pcNow(pcNow), .timerLatch(timerLatch), .busy(busy), .wordCount(wordCount),
  .skipNext(skipNext), .pcLoad(pcLoad), .pcNew(pcNew), .memWr(memWr), .memWrData(memWrData),
  .acc(acc), .carry(carry), .zero(zero), .multiPointer(multiPointer), .timerLoad(timerLoad),
  .timerValue(timerValue));
